// ===== design/hrrs_top.sv
// Host result readout synchronisation logic inside the flow converter.
// Assumes core events arrive synchronously on clk_sys; reg port is same-clock.
`timescale 1ns/1ps
module hrrs_top
(
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire hrrs_pkg::hrrs_event_s core_evt,
    input wire logic [31:0] volume_in,
    input wire logic volume_load,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [8:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    output logic [31:0] reg_rdata,
    output logic host_irq,
    output logic low_voltage_indicator_pin,
    output logic volume_pulse_out,
    output logic chip_idle
);

    // -----------------------------------------------------------------
    // State
    // -----------------------------------------------------------------
    // Local copy of the error word width, needed by the state record below.
    localparam int ERR_W_L = hrrs_pkg::ERR_W;

    // All state of the block gathered in one record.
    typedef struct packed {
        logic [31:0] ts_elapsed;
        logic [31:0] volume;
        logic [31:0] volume_copy;
        logic [31:0] rdata;
        logic [2:0] irq_en;
        logic [ERR_W_L-1:0] err_mask;
        logic [1:0] fw_cfg;
        hrrs_pkg::hrrs_comm_e comm;
        logic irq;
        logic lv_pin;
        logic [7:0] pulse_cnt;
        logic pulse;
        logic err_seen;
    } hrrs_state_s;

    hrrs_state_s st_r;
    hrrs_state_s st_nxt;
    // Volume is valid when both copies agree or protection is off; otherwise the protected copy is reported.
    logic volume_ok;

    assign volume_ok = (st_r.volume == st_r.volume_copy) ||
        !st_r.fw_cfg[hrrs_pkg::CFG_REDUNDANT_BIT];

    // -----------------------------------------------------------------
    // Next state
    // -----------------------------------------------------------------
    // One combinational process computes every next value.
    always_comb
    begin
        st_nxt = st_r;
        st_nxt.irq = 1'b0;
        if (core_evt.tsq_trigger)
        begin
            st_nxt.ts_elapsed = hrrs_pkg::RESET_WORD;
        end
        else
        begin
            st_nxt.ts_elapsed = st_r.ts_elapsed + 32'h0000_0001;
        end
        if (core_evt.meas_done && st_r.irq_en[hrrs_pkg::IRQ_MEAS_BIT])
        begin
            st_nxt.irq = 1'b1;
        end
        if (st_r.irq_en[hrrs_pkg::IRQ_ERR_BIT] && |(core_evt.err_flags & st_r.err_mask))
        begin
            st_nxt.irq = 1'b1;
        end
        if (core_evt.tsq_end && st_r.irq_en[hrrs_pkg::IRQ_TSQ_BIT])
        begin
            st_nxt.irq = 1'b1;
        end
        unique case (st_r.comm)
            hrrs_pkg::HRRS_IDLE:
            begin
                // A request waits until the firmware can answer it.
                if (core_evt.comm_request)
                begin
                    st_nxt.comm = hrrs_pkg::HRRS_PEND;
                end
            end
            hrrs_pkg::HRRS_PEND:
            begin
                if (core_evt.fw_ready)
                begin
                    st_nxt.irq = 1'b1;
                    st_nxt.comm = hrrs_pkg::HRRS_ANSWER;
                end
            end
            hrrs_pkg::HRRS_ANSWER:
            begin
                st_nxt.comm = hrrs_pkg::HRRS_IDLE;
            end
            default:
            begin
                // The fourth code is illegal and recovers to idle.
                st_nxt.comm = hrrs_pkg::HRRS_IDLE;
            end
        endcase
        if (volume_load)
        begin
            st_nxt.volume = volume_in;
            if (st_r.fw_cfg[hrrs_pkg::CFG_REDUNDANT_BIT])
            begin
                st_nxt.volume_copy = volume_in;
            end
        end
        else if (!volume_ok)
        begin
            // Repair the working copy from the protected copy.
            st_nxt.volume = st_r.volume_copy;
        end
        // Without protection the copy shadows the working word, so that switching
        // protection on later does not replace a good volume by a stale copy.
        if (!st_r.fw_cfg[hrrs_pkg::CFG_REDUNDANT_BIT])
        begin
            st_nxt.volume_copy = st_nxt.volume;
        end
        st_nxt.lv_pin = !core_evt.low_voltage;
        st_nxt.err_seen = st_r.err_seen | (|core_evt.err_flags);
        if (st_r.pulse_cnt != 8'h00)
        begin
            st_nxt.pulse_cnt = st_r.pulse_cnt - 8'h01;
        end
        else if (core_evt.volume_pulse)
        begin
            st_nxt.pulse_cnt = 8'(hrrs_pkg::PULSE_CYC);
        end
        else if (st_r.err_seen && st_r.fw_cfg[hrrs_pkg::CFG_PULSE_ERR_BIT])
        begin
            // Error shown as one high pulse twice as long as a volume pulse.
            // An error flagged in this very cycle is kept, so set wins over clear.
            st_nxt.err_seen = |core_evt.err_flags;
            st_nxt.pulse_cnt = 8'(hrrs_pkg::PULSE_CYC * 2);
        end
        st_nxt.pulse = (st_nxt.pulse_cnt != 8'h00);
        // Register writes from the core port.
        if (reg_wr)
        begin
            unique case (reg_addr)
                hrrs_pkg::ADDR_IRQ_CFG:
                begin
                    st_nxt.irq_en = reg_wdata[2:0];
                    st_nxt.err_mask = reg_wdata[16 +: ERR_W_L];
                end
                hrrs_pkg::ADDR_FW_CFG:
                begin
                    st_nxt.fw_cfg = reg_wdata[1:0];
                end
                default:
                begin
                    // Other addresses are read only or unmapped.
                end
            endcase
        end
        // Read data registered one cycle after the strobe.
        if (reg_rd)
        begin
            unique case (reg_addr)
                hrrs_pkg::ADDR_TS_ELAPSED: st_nxt.rdata = st_r.ts_elapsed;
                hrrs_pkg::ADDR_IRQ_CFG: st_nxt.rdata = {st_r.err_mask, 13'h0000, st_r.irq_en};
                hrrs_pkg::ADDR_FW_CFG: st_nxt.rdata = {30'h0000_0000, st_r.fw_cfg};
                hrrs_pkg::ADDR_VOLUME: st_nxt.rdata = volume_ok ? st_r.volume : st_r.volume_copy;
                hrrs_pkg::ADDR_STATUS: st_nxt.rdata = {29'h0000_0000, volume_ok, st_r.comm};
                default: st_nxt.rdata = hrrs_pkg::RESET_WORD;
            endcase
        end
        if (core_evt.watchdog_reset)
        begin
            st_nxt.volume = hrrs_pkg::RESET_WORD;
            st_nxt.volume_copy = hrrs_pkg::RESET_WORD;
            st_nxt.ts_elapsed = hrrs_pkg::RESET_WORD;
            st_nxt.comm = hrrs_pkg::HRRS_IDLE;
        end
    end

    // -----------------------------------------------------------------
    // State register
    // -----------------------------------------------------------------
    // Asynchronous reset loads constants only.
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st_r <= '0;
            st_r.lv_pin <= 1'b1;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    // Outputs straight from state flops, except chip_idle decoded from comm and pulse_cnt.
    assign reg_rdata = st_r.rdata;
    assign host_irq = st_r.irq;
    assign low_voltage_indicator_pin = st_r.lv_pin;
    assign volume_pulse_out = st_r.pulse;
    assign chip_idle = (st_r.comm == hrrs_pkg::HRRS_IDLE) && (st_r.pulse_cnt == 8'h00);

    // -----------------------------------------------------------------
    // Assertions
    // -----------------------------------------------------------------
    meas_irq_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        core_evt.meas_done && st_r.irq_en[hrrs_pkg::IRQ_MEAS_BIT] |=> host_irq)
        else $error("Measurement interrupt missing.");
    err_irq_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        st_r.irq_en[hrrs_pkg::IRQ_ERR_BIT] && |(core_evt.err_flags & st_r.err_mask) |=> host_irq)
        else $error("Error interrupt missing.");
    tsq_irq_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        core_evt.tsq_end && st_r.irq_en[hrrs_pkg::IRQ_TSQ_BIT] |=> host_irq)
        else $error("Sequencer interrupt missing.");
    req_answer_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        st_r.comm == hrrs_pkg::HRRS_PEND && core_evt.fw_ready && !core_evt.watchdog_reset
        |=> host_irq ##1 st_r.comm == hrrs_pkg::HRRS_IDLE)
        else $error("Request not answered.");
    req_clear_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        st_r.comm == hrrs_pkg::HRRS_ANSWER |=> st_r.comm == hrrs_pkg::HRRS_IDLE)
        else $error("Request not cleared.");
    ts_time_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        core_evt.tsq_trigger ##1 !core_evt.tsq_trigger && !core_evt.watchdog_reset
        |=> st_r.ts_elapsed == 32'h0000_0001)
        else $error("Elapsed time wrong.");
    wd_clear_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        core_evt.watchdog_reset |=> st_r.volume == 32'h0 && st_r.volume_copy == 32'h0)
        else $error("Watchdog did not clear data.");
    lv_pin_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        core_evt.low_voltage |=> !low_voltage_indicator_pin)
        else $error("Low voltage pin not low.");
    pulse_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        st_r.pulse_cnt == 8'h00 && core_evt.volume_pulse |=> volume_pulse_out [*8])
        else $error("Volume pulse too short.");
    redund_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        volume_load && st_r.fw_cfg[hrrs_pkg::CFG_REDUNDANT_BIT] && !core_evt.watchdog_reset
        |=> st_r.volume_copy == $past(volume_in))
        else $error("Redundant copy not stored.");

endmodule : hrrs_top

// ===== design/hrrs_pkg.sv
// Package for the host result readout synchronisation block.
// Assumes one 100 MHz clock domain and a word-wide register port from the chip core.
package hrrs_pkg;

    // -----------------------------------------------------------------
    // Register map
    // -----------------------------------------------------------------
    // Elapsed time since the last task sequencer trigger, read only.
    localparam logic [8:0] ADDR_TS_ELAPSED = 9'h0E9;
    // Interrupt configuration word.
    localparam logic [8:0] ADDR_IRQ_CFG = 9'h0EA;
    // Firmware configuration word.
    localparam logic [8:0] ADDR_FW_CFG = 9'h0EB;
    // Flow volume result word.
    localparam logic [8:0] ADDR_VOLUME = 9'h0EC;
    // Status word.
    localparam logic [8:0] ADDR_STATUS = 9'h0ED;

    // -----------------------------------------------------------------
    // Field positions
    // -----------------------------------------------------------------
    // Interrupt configuration bit positions.
    localparam int IRQ_MEAS_BIT = 0;
    localparam int IRQ_ERR_BIT = 1;
    localparam int IRQ_TSQ_BIT = 2;
    // Firmware configuration bit positions.
    localparam int CFG_REDUNDANT_BIT = 0;
    localparam int CFG_PULSE_ERR_BIT = 1;
    // Reset values.
    localparam logic [31:0] RESET_WORD = 32'h0000_0000;
    // Width of the error flag word.
    localparam int ERR_W = 16;

    // Time of a volume pulse; the error pulse burst lasts twice this time.
    localparam int PULSE_NS = 1000;
    localparam int CLK_NS = 10;
    localparam int PULSE_CYC = (PULSE_NS + CLK_NS - 1) / CLK_NS;

    // Events coming from the chip core, same clock.
    typedef struct packed {
        logic meas_done;
        logic tsq_end;
        logic tsq_trigger;
        logic comm_request;
        logic fw_ready;
        logic watchdog_reset;
        logic low_voltage;
        logic volume_pulse;
        logic [ERR_W-1:0] err_flags;
    } hrrs_event_s;

    // Readout controller phases.
    typedef enum logic [1:0] {
        HRRS_IDLE = 2'b00,
        HRRS_PEND = 2'b01,
        HRRS_ANSWER = 2'b10
    } hrrs_comm_e;

endpackage : hrrs_pkg

// ===== test/hrrs_host_model.sv
// Behavioural host controller that reaches the register port of the readout block.
// Assumes it shares clk_sys with the block and drives on the falling edge.
`timescale 1ns/1ps
module hrrs_host_model
(
    input wire logic clk_sys,
    output logic reg_wr,
    output logic reg_rd,
    output logic [8:0] reg_addr,
    output logic [31:0] reg_wdata,
    input wire logic [31:0] reg_rdata,
    output logic rd_valid,
    output logic [31:0] rd_data
);
    // Idle bus at time zero; address and data carry a pattern, not a stale value.
    initial
    begin
        {reg_wr, reg_rd, rd_valid} = 3'h0;
        reg_addr = 9'h155;
        reg_wdata = 32'hA5A5_5A5A;
        rd_data = 32'h0;
    end
    // host access at chosen times.
    // One-cycle write strobe; released fields are inverted so no old value lingers.
    task automatic write(input logic [8:0] a, input logic [31:0] d);
        @(negedge clk_sys);
        {reg_wr, reg_addr, reg_wdata} = {1'b1, a, d};
        @(negedge clk_sys);
        {reg_wr, reg_addr, reg_wdata} = {1'b0, ~a, ~d};
    endtask : write
    // results fetched after events.
    // Read strobe, then the answer is taken one cycle later and flagged for a cycle.
    task automatic read(input logic [8:0] a, output logic [31:0] d);
        @(negedge clk_sys);
        {reg_rd, reg_addr} = {1'b1, a};
        @(negedge clk_sys);
        {reg_rd, reg_addr} = {1'b0, ~a};
        @(negedge clk_sys);
        d = reg_rdata;
        {rd_valid, rd_data} = {1'b1, reg_rdata};
        @(negedge clk_sys);
        rd_valid = 1'b0;
    endtask : read
endmodule : hrrs_host_model

// ===== test/tb.sv
// Self-checking bench for the readout block with a host model on the register port.
// Assumes the hand-over latencies: registered read data, one-cycle interrupt pulse.
`timescale 1ns/1ps
module tb;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    hrrs_pkg::hrrs_event_s core_evt = '0;
    logic [31:0] volume_in = 32'h0;
    logic volume_load = 1'b0;
    logic reg_wr, reg_rd, rd_valid, host_irq, low_voltage_indicator_pin;
    logic volume_pulse_out, chip_idle;
    logic [8:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata, rd_data, v1, v2, vol;
    logic [63:0] exp_rd[$]; // Mask in the upper half, expected word in the lower.
    logic exp_irq[$]; // One note per interrupt pulse that must appear.
    logic [63:0] note; // Oldest read note, taken when an answer appears.
    int num_errors = 0, compares = 0, seed = 32'h4354, hi_cnt = 0, eb;
    initial
    begin
        forever #5 clk_sys = ~clk_sys;
    end
    hrrs_top hrrs_top_inst (.clk_sys(clk_sys), .rst_n(rst_n), .core_evt(core_evt),
        .volume_in(volume_in), .volume_load(volume_load), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .host_irq(host_irq), .low_voltage_indicator_pin(low_voltage_indicator_pin),
        .volume_pulse_out(volume_pulse_out), .chip_idle(chip_idle));
    hrrs_host_model hrrs_host_model_inst (.clk_sys(clk_sys), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .rd_valid(rd_valid), .rd_data(rd_data));
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic stop_test;
        if (num_errors == 0 && compares > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : stop_test
    // Watcher: each read answer or interrupt pulse takes the oldest note.
    always @(posedge clk_sys)
    begin
        if (rd_valid)
        begin
            // An answer with no note left is itself a mismatch.
            note = exp_rd.size() != 0 ? exp_rd.pop_front() : {32'h0, 32'h1};
            check(rd_data & note[63:32], note[31:0]);
        end
        if (host_irq === 1'b1)
            check({31'h0, exp_irq.size() != 0 ? exp_irq.pop_front() : 1'b0}, 32'h1);
        if (volume_pulse_out === 1'b1)
            hi_cnt++;
    end
    // Hang guard: the run may not exceed a fixed cycle budget.
    initial
    begin
        repeat (20000) @(posedge clk_sys);
        num_errors++;
        stop_test();
    end
    // Registered read with an expectation note; mask 0 means value only fetched.
    task automatic rd(input logic [8:0] a, input logic [31:0] e, input logic [31:0] m,
        output logic [31:0] d);
        exp_rd.push_back({m, e & m});
        hrrs_host_model_inst.read(a, d);
    endtask : rd
    // One-cycle core event; the low supply level is left untouched.
    task automatic fire(input int w);
        @(negedge clk_sys);
        case (w)
            0: core_evt.meas_done = 1'b1;
            1: core_evt.tsq_end = 1'b1;
            2: core_evt.err_flags[eb] = 1'b1;
            3: core_evt.tsq_trigger = 1'b1;
            4: core_evt.comm_request = 1'b1;
            5: core_evt.fw_ready = 1'b1;
            6: core_evt.watchdog_reset = 1'b1;
            default: core_evt.volume_pulse = 1'b1;
        endcase
        @(negedge clk_sys);
        core_evt = '{low_voltage: core_evt.low_voltage, default: '0};
    endtask : fire
    initial
    begin
        repeat (6) @(negedge clk_sys);
        rst_n = 1'b1;
        eb = $unsigned($random(seed)) % 16;
        check({31'h0, low_voltage_indicator_pin}, 32'h1);
        rd(hrrs_pkg::ADDR_IRQ_CFG, 32'h0, 32'hFFFF_FFFF, v1);
        rd(hrrs_pkg::ADDR_FW_CFG, 32'h0, 32'hFFFF_FFFF, v1);
        rd(9'h1FF, 32'h0, 32'hFFFF_FFFF, v1);
        // Each enable bit set alone, then cleared with the others on; fire(1) drives tsq_end under the error bit, fire(2) an error flag under the sequencer bit.
        for (int k = 0; k < 3; k++)
        begin
            hrrs_host_model_inst.write(hrrs_pkg::ADDR_IRQ_CFG, 32'hFFFF_0000 | (32'h1 << k));
            exp_irq.push_back(1'b1);
            fire(k);
            hrrs_host_model_inst.write(hrrs_pkg::ADDR_IRQ_CFG, 32'hFFFF_0007 ^ (32'h1 << k));
            fire(k);
        end
        // Error enabled but its flag masked off must stay quiet.
        hrrs_host_model_inst.write(hrrs_pkg::ADDR_IRQ_CFG, 32'h0000_0002);
        fire(2);
        // Ready without a request is ignored; a request is answered once, then cleared.
        fire(5);
        fire(4);
        check({31'h0, chip_idle}, 32'h0);
        rd(hrrs_pkg::ADDR_STATUS, 32'h1, 32'h3, v1);
        exp_irq.push_back(1'b1);
        fire(5);
        rd(hrrs_pkg::ADDR_STATUS, 32'h0, 32'h3, v1);
        check({31'h0, chip_idle}, 32'h1);
        // Elapsed time since trigger; a write to the read-only word is ignored.
        fire(3);
        rd(hrrs_pkg::ADDR_TS_ELAPSED, 32'h0, 32'h0, v1);
        hrrs_host_model_inst.write(hrrs_pkg::ADDR_TS_ELAPSED, 32'h0);
        rd(hrrs_pkg::ADDR_TS_ELAPSED, 32'h0, 32'h0, v2);
        check({31'h0, v1 <= 32'h3}, 32'h1);
        check(v2 - v1, 32'h6);
        // Volume load, refused write, two-value validity check, redundant copy.
        vol = $random(seed);
        @(negedge clk_sys);
        {volume_in, volume_load} = {vol, 1'b1};
        @(negedge clk_sys);
        {volume_in, volume_load} = {~vol, 1'b0};
        hrrs_host_model_inst.write(hrrs_pkg::ADDR_VOLUME, ~vol);
        rd(hrrs_pkg::ADDR_VOLUME, vol, 32'hFFFF_FFFF, v1);
        // two distinct values written and read back.
        hrrs_host_model_inst.write(hrrs_pkg::ADDR_FW_CFG, 32'h1);
        rd(hrrs_pkg::ADDR_FW_CFG, 32'h1, 32'hFFFF_FFFF, v1);
        hrrs_host_model_inst.write(hrrs_pkg::ADDR_FW_CFG, 32'h3);
        rd(hrrs_pkg::ADDR_FW_CFG, 32'h3, 32'hFFFF_FFFF, v1);
        rd(hrrs_pkg::ADDR_STATUS, 32'h4, 32'h4, v1);
        // Plain volume pulse, then an error pulse twice as long.
        hrrs_host_model_inst.write(hrrs_pkg::ADDR_IRQ_CFG, 32'hFFFF_0000);
        // Errors flagged earlier start one error burst once signalling is on; let it drain.
        check({31'h0, chip_idle}, 32'h0);
        repeat (250) @(negedge clk_sys);
        check({31'h0, chip_idle}, 32'h1);
        for (int k = 0; k < 2; k++)
        begin
            hi_cnt = 0;
            fire(k == 0 ? 7 : 2);
            repeat (250) @(negedge clk_sys);
            check(32'(hi_cnt), 32'(hrrs_pkg::PULSE_CYC * (k + 1)));
        end
        // Low supply drives the indicator low; recovery drives it high again.
        core_evt.low_voltage = 1'b1;
        repeat (2) @(negedge clk_sys);
        check({31'h0, low_voltage_indicator_pin}, 32'h0);
        core_evt.low_voltage = 1'b0;
        repeat (2) @(negedge clk_sys);
        check({31'h0, low_voltage_indicator_pin}, 32'h1);
        // Watchdog clears the volume and restarts the elapsed count.
        fire(6);
        rd(hrrs_pkg::ADDR_VOLUME, 32'h0, 32'hFFFF_FFFF, v1);
        rd(hrrs_pkg::ADDR_TS_ELAPSED, 32'h0, 32'h0, v1);
        check({31'h0, v1 <= 32'h8}, 32'h1);
        repeat (4) @(negedge clk_sys);
        check(32'(exp_irq.size() + exp_rd.size()), 32'h0);
        stop_test();
    end
endmodule : tb
